// [dv/i2css_mmodel.sv]
// Bus master model: start, bytes and stop on an open-drain two-wire bus.
// Assumes the bench resolves the wires with pull-ups; it waits out clock holds.
`timescale 1ns/1ps
module i2css_mmodel (
  input wire logic pclk,
  input wire logic scl,
  input wire logic sda,
  output logic scl_low,
  output logic sda_low
);
  localparam int H = 6;
  initial
  begin
    scl_low = 1'b0;
    sda_low = 1'b0;
  end
  task automatic hw();
    repeat (H) @(posedge pclk);
  endtask
  // Release the clock; a slave may hold it low for as long as it likes
  task automatic rise();
    scl_low <= 1'b0;
    @(posedge pclk);
    while (scl !== 1'b1)
      @(posedge pclk);
    hw();
  endtask
  task automatic start();
    sda_low <= 1'b1;
    hw();
    scl_low <= 1'b1;
    hw();
  endtask
  // Data set while the clock is low, sampled late in the high phase
  task automatic bit1(input logic b, output logic r);
    sda_low <= !b;
    hw();
    rise();
    r = sda;
    scl_low <= 1'b1;
    @(posedge pclk);
  endtask
  task automatic xfer(input logic [7:0] d, input logic ab, output logic [7:0] r,
      output logic a);
    for (int i = 7; i >= 0; i--)
      bit1(d[i], r[i]);
    bit1(ab, a);
  endtask
  task automatic stop();
    sda_low <= 1'b1;
    hw();
    rise();
    sda_low <= 1'b0;
    hw();
  endtask
endmodule

// [dv/i2css_top_sva.sv]
// Checker for the slave status block: bus handshake, clock hold, flags.
// Assumes it is bound into i2css_top and sees only its ports.
`timescale 1ns/1ps
module i2css_top_sva
  import i2css_pkg::*;
#(
  parameter int T_LOW_CYCLES = 4
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic scl_i,
  input wire logic scl_o,
  input wire logic scl_oe,
  input wire logic sda_i,
  input wire logic sda_o,
  input wire logic sda_oe,
  input wire logic bus_interface_interrupt
);
  logic acc;
  logic srd;
  logic svc;
  int cnt_r;
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  // Access edge decode; a data access or pin write services a held clock
  assign acc = psel && penable && pready;
  assign srd = acc && !pwrite && paddr == OFF_STAT;
  assign svc = acc && scl_oe && (paddr == OFF_DATA || (pwrite && paddr == OFF_CTRL
    && pwdata[CTRL_PIN_BIT]));
  // Cycles since service; a second service is ignored so the bound stays strict
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      cnt_r <= 0;
    else if (svc && cnt_r == 0)
      cnt_r <= 1;
    else if (!scl_oe)
      cnt_r <= 0;
    else if (cnt_r != 0)
      cnt_r <= cnt_r + 1;
  end
  a_ready_next: assert property (psel && !penable |=> pready)
    else $error("pready missing after setup");
  a_err_unmapped: assert property (acc && paddr > OFF_IMASK |-> pslverr)
    else $error("no error on unmapped address");
  a_err_ready: assert property (pslverr |-> pready)
    else $error("error without ready");
  a_release_early: assert property ($fell(scl_oe) |-> cnt_r >= T_LOW_CYCLES)
    else $error("clock released too early");
  a_release_late: assert property (cnt_r <= T_LOW_CYCLES + 4)
    else $error("clock held too long");
  a_pin_held: assert property (srd && scl_oe && $past(scl_oe) && cnt_r == 0 |-> !prdata[4])
    else $error("pin set while clock held");
  a_lost_unmatched: assert property (srd && prdata[2] && !prdata[1] |-> prdata[3:0] == 4'h4)
    else $error("flags wrong after unmatched loss");
  a_lost_read: assert property (srd && prdata[3] && prdata[2] |-> prdata[1:0] == 2'b10)
    else $error("flags wrong after loss to read");
  a_sda_low_phase: assert property ($changed(sda_oe) |-> !scl_i)
    else $error("data changed while clock high");
  a_od_zero: assert property (!scl_o && !sda_o)
    else $error("open drain value not zero");
  c_service: cover property (svc);
  c_lost: cover property (srd && prdata[2]);
  c_unmapped: cover property (acc && pslverr);
endmodule
bind i2css_top i2css_top_sva #(.T_LOW_CYCLES(T_LOW_CYCLES)) i_sva (.pclk, .presetn, .psel,
  .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr, .scl_i, .scl_o, .scl_oe,
  .sda_i, .sda_o, .sda_oe, .bus_interface_interrupt);

// [dv/tb_i2css_top.sv]
// Bench for the slave status block: APB master, bus master model, checks.
// Assumes a shortened clock hold timer and pull-ups on both bus wires.
`timescale 1ns/1ps
module tb_i2css_top;
  import i2css_pkg::*;
  localparam int TL = 4;
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata;
  logic pready, pslverr, scl_o, scl_oe, sda_o, sda_oe, irq, m_scl, m_sda, err;
  logic [31:0] rd;
  int errors = 0;
  int n_checks = 0;
  int seed = 91387;
  int cyc = 0;
  // Wired-AND bus: released lines are pulled high
  wire logic scl = !(scl_oe || m_scl);
  wire logic sda = !(sda_oe || m_sda);
  always #20 pclk = !pclk;
  i2css_top #(.T_LOW_CYCLES(TL)) i_i2css_top (.pclk, .presetn, .psel, .penable, .pwrite,
    .paddr, .pwdata, .prdata, .pready, .pslverr, .scl_i(scl), .scl_o, .scl_oe, .sda_i(sda),
    .sda_o, .sda_oe, .bus_interface_interrupt(irq));
  i2css_mmodel i_i2css_mmodel (.pclk, .scl, .sda, .scl_low(m_scl), .sda_low(m_sda));
  task automatic check(input logic [31:0] seen, input logic [31:0] exp, input string what);
    n_checks++;
    if (seen !== exp)
    begin
      errors++;
      $display("wrong value at %0t: %s seen %h expected %h", $time, what, seen, exp);
    end
  endtask
  task automatic results();
    $display("checks %0d mismatches %0d", n_checks, errors);
    if (errors == 0 && n_checks > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask
  // One APB transfer; waits for pready, takes data at that edge
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] v);
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= v;
    @(posedge pclk);
    penable <= 1'b1;
    do
      @(posedge pclk);
    while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  // Address phase, flag check, then the software service the flags call for
  task automatic run(input logic [6:0] own, input logic [7:0] mb, input logic [7:0] ad,
      input logic [3:0] ef, input logic [3:0] msk);
    logic [7:0] d;
    logic [7:0] r;
    logic a;
    d = 8'($random(seed));
    apb(1, OFF_IMASK, {28'h0, msk});
    apb(1, OFF_OADR, {24'h0, own, 1'b0});
    if (mb != 8'h00)
    begin
      apb(1, OFF_CTRL, 32'h05);
      apb(1, OFF_DATA, {24'h0, mb});
    end
    i_i2css_mmodel.start();
    i_i2css_mmodel.xfer(ad, 1'b1, r, a);
    check(a, !ef[1], "address ack");
    repeat (3) @(posedge pclk);
    check(scl_oe, 1'b1, "clock hold");
    apb(0, OFF_STAT, 0);
    check(rd[4:0], {1'b0, ef}, "flags");
    check(irq, |msk, "interrupt");
    apb(0, OFF_ISTAT, 0);
    repeat (2) @(posedge pclk);
    check(irq, 1'b0, "interrupt clear");
    apb(0, OFF_CTRL, 0);
    check(rd[0], 1'b0, "master mode");
    if (ef[3])
    begin
      apb(1, OFF_CTRL, 32'h04);
      apb(1, OFF_DATA, {24'h0, d});
      i_i2css_mmodel.xfer(8'hff, 1'b1, r, a);
      check(r, d, "sent byte");
      repeat (3) @(posedge pclk);
      apb(0, OFF_STAT, 0);
      check({rd[6], rd[4:0]}, 6'h28, "sent word flags");
      apb(1, OFF_CTRL, 32'h02);
    end
    else if (ef[1])
    begin
      apb(0, OFF_DATA, 0);
      i_i2css_mmodel.xfer(d, 1'b1, r, a);
      check(a, 1'b0, "data ack");
      repeat (3) @(posedge pclk);
      apb(0, OFF_STAT, 0);
      check(rd[3:1], 3'h0, "word flags");
      apb(0, OFF_DATA, 0);
      check(rd[7:0], d, "received byte");
    end
    else
      apb(0, OFF_DATA, 0);
    i_i2css_mmodel.stop();
    $display("test done: own %h address %h", own, ad);
  endtask
  // Hang guard, far above the expected run
  always @(posedge pclk)
  begin
    cyc++;
    if (cyc == 30000)
    begin
      errors++;
      results();
    end
  end
  initial
  begin
    repeat (20) @(posedge pclk);
    presetn <= 1'b1;
    apb(0, OFF_STAT, 0);
    check(rd, 32'h10, "status reset");
    apb(0, OFF_CTRL, 0);
    check(rd, 32'h02, "control reset");
    apb(0, OFF_OADR, 0);
    check(rd, {24'h0, OADR_RST, 1'b0}, "address reset");
    apb(0, OFF_IMASK, 0);
    check(rd, 32'h0, "mask reset");
    apb(1, 8'h18, 32'hffffffff);
    check(err, 1'b1, "unmapped error");
    check(rd, 32'h0, "unmapped data");
    $display("test done: registers");
    run(7'h2a, 8'h00, 8'h54, 4'h2, 4'hf);
    run(7'h2a, 8'h00, 8'h00, 4'h3, 4'hf);
    run(7'h2a, 8'h00, 8'h55, 4'ha, 4'h0);
    run(7'h00, 8'h00, 8'h01, 4'ha, 4'hf);
    run(7'h2a, 8'hd5, 8'h55, 4'he, 4'hf);
    run(7'h2a, 8'hd4, 8'h54, 4'h6, 4'hf);
    run(7'h2a, 8'ha0, 8'h20, 4'h4, 4'hf);
    results();
  end
endmodule

// [hdl/i2css_busev.sv]
// Pin event detector: SCL edges, start and stop conditions.
// Assumes scl and sda are already synchronous to pclk.
`timescale 1ns/1ps
module i2css_busev
  import i2css_pkg::*;
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic scl_i,
  input wire logic sda_i,
  output i2css_pkg::i2css_ev_t ev
);
  logic scl_q_r;
  logic sda_q_r;

  // Previous pin levels; idle bus reads high
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      scl_q_r <= 1'b1;
      sda_q_r <= 1'b1;
    end
    else
    begin
      scl_q_r <= scl_i;
      sda_q_r <= sda_i;
    end
  end

  // SDA changing while SCL stays high marks start or stop
  assign ev.scl_rise = scl_i & ~scl_q_r;
  assign ev.scl_fall = ~scl_i & scl_q_r;
  assign ev.start = scl_i & scl_q_r & sda_q_r & ~sda_i;
  assign ev.stop = scl_i & scl_q_r & ~sda_q_r & sda_i;
  assign ev.sda = sda_i;
endmodule

// [hdl/i2css_lowtmr.sv]
// One-shot timer for the SCL low period before releasing a held clock.
// Assumes start is a one-cycle pulse; a restart while busy reloads.
`timescale 1ns/1ps
module i2css_lowtmr #(
  parameter int CYC = 118
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic start,
  output logic done
);
  localparam int CW = $clog2(CYC + 1);
  logic [CW-1:0] cnt_r;

  if (CYC < 1)
  begin : g_bad_cyc
    $error("i2css_lowtmr: CYC must be at least 1");
  end

  // Down counter; done pulses as it reaches one
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      cnt_r <= '0;
    else if (start)
      cnt_r <= CW'(CYC);
    else if (cnt_r != '0)
      cnt_r <= cnt_r - 1'b1;
  end

  assign done = (cnt_r == CW'(1));
endmodule

// [hdl/i2css_pkg.sv]
// Shared constants and types for the two-wire slave-mode status block.
// Assumes a 25 MHz APB clock; all offsets are byte addresses.
package i2css_pkg;

  // Register byte offsets
  localparam logic [7:0] OFF_CTRL = 8'h00;
  localparam logic [7:0] OFF_STAT = 8'h04;
  localparam logic [7:0] OFF_DATA = 8'h08;
  localparam logic [7:0] OFF_OADR = 8'h0c;
  localparam logic [7:0] OFF_ISTAT = 8'h10;
  localparam logic [7:0] OFF_IMASK = 8'h14;

  // Field positions of control_reg_one
  localparam int CTRL_MST_BIT = 0;
  localparam int CTRL_PIN_BIT = 1;
  localparam int CTRL_TRX_BIT = 2;
  localparam int CTRL_BC_LSB = 5;
  // Own address sits in bits 7:1 of own_address_reg
  localparam int OADR_LSB = 1;

  // Reset values
  localparam logic [2:0] BC_RST = 3'h0;
  localparam logic [6:0] OADR_RST = 7'h7f;
  localparam logic [3:0] IMASK_RST = 4'h0;

  // Special bytes on the bus
  localparam logic [7:0] GCALL_BYTE = 8'h00;
  localparam logic [7:0] START_BYTE = 8'h01;
  localparam logic [6:0] ZERO_ADDR = 7'h00;
  localparam logic [3:0] ADDR_BITS = 4'h8;

  // Timing
  localparam int CLK_NS = 40;
  localparam int T_LOW_NS = 4700;
  localparam int T_LOW_CYC = (T_LOW_NS + CLK_NS - 1) / CLK_NS;

  // Status flags, low bits of status_reg
  typedef struct packed {
    logic lrb;
    logic bb;
    logic pin;
    logic trx;
    logic al;
    logic aas;
    logic ad0;
  } i2css_stat_t;

  // Sticky interrupt events, same layout in mask register
  typedef struct packed {
    logic al;
    logic word;
    logic gcall;
    logic amatch;
  } i2css_irq_t;

  // Bus events seen on the pins
  typedef struct packed {
    logic scl_rise;
    logic scl_fall;
    logic start;
    logic stop;
    logic sda;
  } i2css_ev_t;

  // Bit engine states, Gray along the usual path
  typedef enum logic [2:0] {
    ST_IDLE = 3'b000,
    ST_ADDR = 3'b001,
    ST_AACK = 3'b011,
    ST_DATA = 3'b010,
    ST_DACK = 3'b110
  } i2css_state_t;

endpackage

// [hdl/i2css_top.sv]
// Slave-mode two-wire bus interface with APB registers and status flags.
// Assumes SCL/SDA inputs synchronous to pclk; open-drain pins resolved outside.
// Behaviour
// - Lost arbitration then matched read address: trx, al, aas set, gcall clear.
// - Lost arbitration then write address or general call: trx clear, al, aas set.
// - Lost arbitration, unmatched or data word: al set; trx, aas, gcall and pin clear.
// - Data buffer read or pin write of 1 services the word and sets pin.
// - Slave receiver address or general call: aas set, trx and al clear.
// - After each received word trx, al, aas read clear; software reads data.
// - With own address zero a start byte matches and sets trx.
// - Lost arbitration as master drops to slave mode.
// - Word with lost arbitration ends: interrupt, pin cleared, SCL held low.
// - Data access or pin set releases held SCL after one low period.
`timescale 1ns/1ps
module i2css_top #(
  parameter int T_LOW_CYCLES = i2css_pkg::T_LOW_CYC
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic scl_i,
  output logic scl_o,
  output logic scl_oe,
  input wire logic sda_i,
  output logic sda_o,
  output logic sda_oe,
  output logic bus_interface_interrupt
);
  import i2css_pkg::*;

  // Data word length; zero bit count means a full byte
  function automatic logic [3:0] word_len(input logic [2:0] bc);
    word_len = (bc == 3'h0) ? 4'h8 : {1'b0, bc};
  endfunction

  i2css_state_t state_r;
  i2css_stat_t stat_r;
  i2css_irq_t ists_r, imask_r, ev_set, ists_nxt;
  i2css_ev_t ev;
  logic [3:0] cnt_r;
  logic [7:0] rx_sh_r, tx_sh_r, rx_data_r;
  logic [2:0] bc_r;
  logic [6:0] oadr_r;
  logic mst_r, hold_r, sda_oe_r, irq_r, zero_r;
  logic [31:0] prdata_r;
  logic pready_r, pslverr_r;
  logic tmr_done;

  if (T_LOW_CYCLES < 1)
  begin : g_bad_tlow
    $error("i2css_top: T_LOW_CYCLES must be at least 1");
  end

  i2css_busev u_busev (
    .pclk(pclk),
    .presetn(presetn),
    .scl_i(scl_i),
    .sda_i(sda_i),
    .ev(ev)
  );

  // APB access strobes
  wire acc = psel & penable & pready_r;
  wire wr = acc & pwrite;
  wire rd = acc & ~pwrite;
  logic sel_ctrl, sel_stat, sel_data, sel_oadr, sel_ists, sel_imask;

  // Address decode
  always_comb
  begin
    sel_ctrl = 1'b0;
    sel_stat = 1'b0;
    sel_data = 1'b0;
    sel_oadr = 1'b0;
    sel_ists = 1'b0;
    sel_imask = 1'b0;
    if (paddr == OFF_CTRL)
      sel_ctrl = 1'b1;
    else if (paddr == OFF_STAT)
      sel_stat = 1'b1;
    else if (paddr == OFF_DATA)
      sel_data = 1'b1;
    else if (paddr == OFF_OADR)
      sel_oadr = 1'b1;
    else if (paddr == OFF_ISTAT)
      sel_ists = 1'b1;
    else if (paddr == OFF_IMASK)
      sel_imask = 1'b1;
  end
  wire mapped = sel_ctrl | sel_stat | sel_data | sel_oadr | sel_ists | sel_imask;

  // Software accesses that free a held clock: data write or read, pin write of 1
  wire data_wr = wr & sel_data;
  wire data_rd = rd & sel_data;
  wire pin_wr = wr & sel_ctrl & pwdata[CTRL_PIN_BIT];
  wire sw_release = data_wr | data_rd | pin_wr;

  // Address comparison on the completed first byte
  wire gcall = (rx_sh_r == GCALL_BYTE) & (oadr_r != ZERO_ADDR);
  wire sbyte = (oadr_r == ZERO_ADDR) & (rx_sh_r == START_BYTE);
  wire amatch = ((oadr_r != ZERO_ADDR) & (rx_sh_r[7:1] == oadr_r)) | sbyte;
  wire rd_dir = rx_sh_r[0] | sbyte;
  wire hit = amatch | gcall;

  // Word progress and arbitration check
  wire [3:0] wlen = (state_r == ST_ADDR) ? ADDR_BITS : word_len(bc_r);
  wire word_end = ev.scl_fall & (cnt_r == wlen);
  wire in_word = (state_r == ST_ADDR) | (state_r == ST_DATA);
  wire txing = (mst_r & (state_r == ST_ADDR)) | (stat_r.trx & (state_r == ST_DATA));
  wire al_now = ev.scl_rise & txing & mst_r & tx_sh_r[7] & ~ev.sda;

  // Events that raise the interrupt; al events at the address ack slot or as a data word ends
  assign ev_set.amatch = (state_r == ST_AACK) & ev.scl_fall & amatch;
  assign ev_set.gcall = (state_r == ST_AACK) & ev.scl_fall & gcall;
  assign ev_set.word = (state_r == ST_DACK) & ev.scl_fall;
  // Unmatched loss raises at its ack slot, so the ninth clock is never held mid-bit
  assign ev_set.al = stat_r.al & (((state_r == ST_AACK) & ev.scl_fall & ~stat_r.aas)
                     | (word_end & ~stat_r.aas & (state_r == ST_DATA))
                     | ev_set.amatch | ev_set.gcall);
  wire irq_evt = |ev_set;
  // Sticky status, set wins over the clearing read
  assign ists_nxt = ((rd & sel_ists) ? '0 : ists_r) | ev_set;

  // Timer for the SCL low period after release
  i2css_lowtmr #(
    .CYC(T_LOW_CYCLES)
  ) u_lowtmr (
    .pclk(pclk),
    .presetn(presetn),
    .start(sw_release & hold_r),
    .done(tmr_done)
  );

  // APB answer: one wait-free access phase, read data from setup
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      pready_r <= 1'b0;
      pslverr_r <= 1'b0;
      prdata_r <= '0;
    end
    else
    begin
      pready_r <= psel & ~penable;
      pslverr_r <= psel & ~penable & ~mapped;
      if (psel & ~penable & ~pwrite)
        prdata_r <= sel_ctrl ? {24'h0, bc_r, 2'h0, stat_r.trx, stat_r.pin, mst_r}
                  : sel_stat ? {25'h0, stat_r}
                  : sel_data ? {24'h0, rx_data_r}
                  : sel_oadr ? {24'h0, oadr_r, 1'b0}
                  : sel_ists ? {28'h0, ists_r}
                  : sel_imask ? {28'h0, imask_r} : 32'h0;
    end
  end

  // Plain software registers
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      bc_r <= BC_RST;
      oadr_r <= OADR_RST;
      imask_r <= IMASK_RST;
      ists_r <= '0;
      irq_r <= 1'b0;
      zero_r <= 1'b0;
    end
    else
    begin
      if (wr & sel_ctrl)
        bc_r <= pwdata[CTRL_BC_LSB +: 3];
      if (wr & sel_oadr)
        oadr_r <= pwdata[OADR_LSB +: 7];
      if (wr & sel_imask)
        imask_r <= pwdata[3:0];
      ists_r <= ists_nxt;
      irq_r <= |(ists_nxt & imask_r);
      zero_r <= 1'b0;
    end
  end

  // SCL hold: set by each serviced word, freed one low period after software acts
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      hold_r <= 1'b0;
    else if (irq_evt)
      hold_r <= 1'b1;
    else if (tmr_done)
      hold_r <= 1'b0;
  end

  // Bit engine and status flags; hardware updates override software writes
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      state_r <= ST_IDLE;
      stat_r <= '{lrb: 1'b0, bb: 1'b0, pin: 1'b1, trx: 1'b0, al: 1'b0, aas: 1'b0, ad0: 1'b0};
      mst_r <= 1'b0;
      cnt_r <= '0;
      rx_sh_r <= '0;
      tx_sh_r <= '0;
      rx_data_r <= '0;
      sda_oe_r <= 1'b0;
    end
    else
    begin
      // Software side: mode bits, pin set, transmit load
      if (wr & sel_ctrl)
      begin
        mst_r <= pwdata[CTRL_MST_BIT];
        stat_r.trx <= pwdata[CTRL_TRX_BIT];
      end
      if (sw_release)
        stat_r.pin <= 1'b1;
      if (data_wr)
      begin
        tx_sh_r <= pwdata[7:0];
        if (stat_r.trx & (state_r == ST_DATA))
          sda_oe_r <= ~pwdata[7];
      end
      // Bus side
      if (ev.stop)
      begin
        state_r <= ST_IDLE;
        stat_r.bb <= 1'b0;
        sda_oe_r <= 1'b0;
      end
      else if (ev.start)
      begin
        state_r <= ST_ADDR;
        stat_r.bb <= 1'b1;
        cnt_r <= '0;
        sda_oe_r <= 1'b0;
      end
      else if (ev.scl_rise)
      begin
        if (in_word)
        begin
          rx_sh_r <= {rx_sh_r[6:0], ev.sda};
          tx_sh_r <= {tx_sh_r[6:0], 1'b0};
          cnt_r <= cnt_r + 4'h1;
        end
        if ((state_r == ST_DACK) & stat_r.trx)
          stat_r.lrb <= ev.sda;
        if (al_now)
        begin
          mst_r <= 1'b0;
          stat_r.al <= 1'b1;
          stat_r.trx <= 1'b0;
          sda_oe_r <= 1'b0;
        end
      end
      else if (ev.scl_fall)
      begin
        case (state_r)
          ST_ADDR:
          begin
            if (cnt_r != wlen)
              sda_oe_r <= txing & ~tx_sh_r[7];
            else if (mst_r)
            begin
              state_r <= ST_AACK;
              sda_oe_r <= 1'b0;
            end
            else if (hit)
            begin
              state_r <= ST_AACK;
              stat_r.aas <= 1'b1;
              stat_r.ad0 <= gcall;
              stat_r.trx <= amatch & rd_dir;
              sda_oe_r <= 1'b1;
            end
            else
            begin
              state_r <= stat_r.al ? ST_AACK : ST_IDLE;
              sda_oe_r <= 1'b0;
              if (stat_r.al)
              begin
                stat_r.trx <= 1'b0;
                stat_r.aas <= 1'b0;
                stat_r.ad0 <= 1'b0;
                stat_r.pin <= 1'b0;
              end
            end
          end
          ST_AACK:
          begin
            state_r <= (stat_r.al & ~stat_r.aas) ? ST_IDLE : ST_DATA;
            cnt_r <= '0;
            sda_oe_r <= 1'b0;
            if (hit & ~mst_r)
              stat_r.pin <= 1'b0;
          end
          ST_DATA:
          begin
            if (cnt_r != wlen)
              sda_oe_r <= txing & ~tx_sh_r[7];
            else if (stat_r.al & ~stat_r.aas)
            begin
              state_r <= ST_IDLE;
              stat_r.trx <= 1'b0;
              stat_r.aas <= 1'b0;
              stat_r.ad0 <= 1'b0;
              stat_r.pin <= 1'b0;
              sda_oe_r <= 1'b0;
            end
            else
            begin
              state_r <= ST_DACK;
              sda_oe_r <= ~stat_r.trx & ~mst_r;
            end
          end
          ST_DACK:
          begin
            state_r <= ST_DATA;
            cnt_r <= '0;
            rx_data_r <= rx_sh_r;
            stat_r.aas <= 1'b0;
            stat_r.al <= 1'b0;
            stat_r.pin <= 1'b0;
            sda_oe_r <= 1'b0;
          end
          default:
            sda_oe_r <= 1'b0;
        endcase
      end
    end
  end

  // Open-drain pins only ever pull low
  assign scl_o = zero_r;
  assign sda_o = zero_r;
  assign scl_oe = hold_r;
  assign sda_oe = sda_oe_r;
  assign bus_interface_interrupt = irq_r;
  assign prdata = prdata_r;
  assign pready = pready_r;
  assign pslverr = pslverr_r;
endmodule
